/* File: logic/flash_guard_pkg.sv */
// Purpose: Shared constants and carriers for the flash region guard.
// Assumes: 250 MHz CPU clock, 14-bit program addresses.
// Notes:   Offsets are special-register addresses on the CPU's register port.
package flash_guard_pkg;

    localparam int          ADDR_W          = 14;
    localparam logic [13:0] VECTOR_END      = 14'h006F;
    localparam logic [13:0] LOCK_END        = 14'h01FF;
    localparam logic [13:0] ALL_END         = 14'h3EFF;
    localparam logic [13:0] FREE_START      = 14'h3F00;
    localparam logic [13:0] FREE_END        = 14'h3FEF;
    localparam logic [13:0] CFG_START       = 14'h3FF0;
    localparam logic [13:0] CFG_OPEN_END    = 14'h3FF7;
    localparam logic [13:0] CFG_GUARD_END   = 14'h3FFE;
    localparam logic [13:0] CFG_HIGH_ADDR   = 14'h3FFF;
    localparam logic [13:0] CFG_LOW_ADDR    = 14'h3FFD;
    localparam logic [13:0] CFG_BG_ADDR     = 14'h3FFB;
    localparam logic [13:0] DATA_LO_LARGE   = 14'h3000;
    localparam logic [13:0] DATA_LO_SMALL   = 14'h1000;
    localparam logic [13:0] DATA_HI_SMALL   = 14'h1FEF;
    localparam logic [13:0] SMALL_MASK      = 14'h1FFF;

    localparam logic [7:0]  SOFTWARE_COMMAND_OFS = 8'h97;
    localparam logic [7:0]  BANDGAP_TRIM_OFS     = 8'hF5;
    localparam logic [7:0]  CONFIG_LOW_OFS       = 8'hF6;
    localparam logic [7:0]  WRITE_UNLOCK_OFS     = 8'hC9;
    localparam logic [7:0]  WIDE_UNLOCK_KEY      = 8'h65;
    localparam logic [7:0]  WRITE_UNLOCK_KEY     = 8'h47;
    localparam logic [7:0]  BYTE_RESET           = 8'h00;
    localparam int          LOCK_BIT             = 1;

    localparam int          CLK_MHZ         = 250;
    localparam int          WRITE_TIME_US   = 1000;
    localparam int          WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;
    localparam int          CNT_W           = 18;

    typedef struct packed {
        logic        valid;
        logic        is_data;
        logic        is_write;
        logic [13:0] addr;
        logic [7:0]  wdata;
    } access_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : flash_guard_pkg

/* File: logic/flash_region_decode.sv */
// Purpose: Combinational region decode and access verdict.
// Assumes: Address as the CPU issues it; the top passes acc_in.addr unfolded.
// Notes:   Pure logic; the top registers its verdict.
`timescale 1ns/10ps
module flash_region_decode #(
    parameter bit LARGE = 1'b1
) (
    // Access under test
    input  wire logic [13:0] addr_in,
    input  wire logic        is_data_in,
    // Protection state
    input  wire logic        lock_cfg_in,
    input  wire logic        wide_unlock_in,
    // Verdict
    output logic             allow_out,
    output logic             in_data_area_out
);

    always_comb begin
        allow_out = 1'b1;
        if (addr_in <= flash_guard_pkg::LOCK_END) begin
            // Vector entries fetch as ordinary code under the same policy.
            if (lock_cfg_in) begin
                allow_out = 1'b0;
            end else begin
                allow_out = !is_data_in || wide_unlock_in;
            end
        end else if (addr_in <= flash_guard_pkg::ALL_END) begin
            allow_out = !is_data_in || wide_unlock_in;
        end else if (addr_in <= flash_guard_pkg::FREE_END) begin
            allow_out = 1'b1;
        end else if (addr_in <= flash_guard_pkg::CFG_OPEN_END) begin
            allow_out = 1'b1;
        end else if (addr_in <= flash_guard_pkg::CFG_GUARD_END) begin
            allow_out = !is_data_in || wide_unlock_in;
        end else begin
            allow_out = !is_data_in;
        end
    end

    // Data region for in-application use differs per variant.
    always_comb begin
        if (LARGE) begin
            in_data_area_out = (addr_in >= flash_guard_pkg::DATA_LO_LARGE) &&
                               (addr_in <= flash_guard_pkg::FREE_END);
        end else begin
            in_data_area_out = (addr_in >= flash_guard_pkg::DATA_LO_SMALL) &&
                               (addr_in <= flash_guard_pkg::DATA_HI_SMALL);
        end
    end

endmodule : flash_region_decode

/* File: logic/flash_iap_region_guard.sv */
// Purpose: Access guard for program flash code fetches and data accesses.
// Assumes: CPU holds a request until ready; one access in flight at a time.
// Notes:   Flash array is modelled as a register array.
`timescale 1ns/10ps
module flash_iap_region_guard #(
    parameter bit LARGE        = 1'b1,
    parameter int WRITE_CYCLES = flash_guard_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     por_in,
    // Flash access port
    input  wire flash_guard_pkg::access_s acc_in,
    output logic                          acc_ready_out,
    output logic                          acc_rvalid_out,
    output logic [7:0]                    acc_rdata_out,
    output logic                          acc_blocked_out,
    output logic                          cpu_stall_out,
    // Register port
    input  wire flash_guard_pkg::reg_req_s reg_in,
    output logic [7:0]                    reg_rdata_out,
    // Configuration outputs
    output logic [7:0]                    config_low_out,
    output logic [7:0]                    bandgap_trim_out,
    output logic                          fetch_lock_cfg_out
);

    localparam int DEPTH = LARGE ? 16384 : 8192;

    typedef enum {ST_LOAD_HI, ST_LOAD_LO, ST_LOAD_BG, ST_IDLE, ST_WRITE}
        state_e;

    localparam int CNT_W_L = flash_guard_pkg::CNT_W;
    localparam logic [17:0] WRITE_LAST = 18'(WRITE_CYCLES - 1);

    // Cells start erased, as an unprogrammed part reads all ones; this also
    // keeps the lock bit defined before any configuration is stored.
    logic [7:0]  mem [DEPTH] = '{default: 8'hFF};
    state_e      state;
    state_e      next_state;
    logic [CNT_W_L-1:0] cnt;
    logic [CNT_W_L-1:0] next_cnt;

    logic        wide_unlock;
    logic        next_wide_unlock;
    logic        write_unlock;
    logic        next_write_unlock;
    logic        lock_cfg;
    logic        next_lock_cfg;
    logic [7:0]  cfg_low;
    logic [7:0]  next_cfg_low;
    logic [7:0]  trim;
    logic [7:0]  next_trim;
    logic        ready;
    logic        next_ready;
    logic        rvalid;
    logic        next_rvalid;
    logic [7:0]  rdata;
    logic [7:0]  next_rdata;
    logic        blocked;
    logic        next_blocked;
    logic [7:0]  rreg;
    logic [7:0]  next_rreg;
    logic [13:0] waddr;
    logic [13:0] next_waddr;
    logic [7:0]  wbyte;
    logic [7:0]  next_wbyte;
    logic        commit;
    logic        stall;
    logic        next_stall;

    logic [13:0] addr_f;
    logic        allow;
    logic        in_data;
    logic [13:0] hi_addr;
    logic [13:0] lo_addr;
    logic [13:0] bg_addr;

    // Small variant mirrors the top of its map onto the 16K address space.
    function automatic logic [13:0] fold(input logic [13:0] a);
        fold = LARGE ? a : (a & flash_guard_pkg::SMALL_MASK);
    endfunction : fold

    assign addr_f  = fold(acc_in.addr);
    assign hi_addr = fold(flash_guard_pkg::CFG_HIGH_ADDR);
    assign lo_addr = fold(flash_guard_pkg::CFG_LOW_ADDR);
    assign bg_addr = fold(flash_guard_pkg::CFG_BG_ADDR);

    flash_region_decode #(
        .LARGE            (LARGE)
    ) u_decode (
        .addr_in          (acc_in.addr),
        .is_data_in       (acc_in.is_data),
        .lock_cfg_in      (lock_cfg),
        .wide_unlock_in   (wide_unlock),
        .allow_out        (allow),
        .in_data_area_out (in_data)
    );

    always_comb begin
        next_state        = state;
        next_cnt          = cnt;
        next_wide_unlock  = wide_unlock;
        next_write_unlock = write_unlock;
        next_lock_cfg     = lock_cfg;
        next_cfg_low      = cfg_low;
        next_trim         = trim;
        next_ready        = 1'b0;
        next_rvalid       = 1'b0;
        next_rdata        = rdata;
        next_blocked      = 1'b0;
        next_rreg         = rreg;
        next_waddr        = waddr;
        next_wbyte        = wbyte;
        commit            = 1'b0;

        if (reg_in.wr) begin
            case (reg_in.addr)
                flash_guard_pkg::SOFTWARE_COMMAND_OFS: begin
                    next_wide_unlock =
                        (reg_in.wdata == flash_guard_pkg::WIDE_UNLOCK_KEY);
                end
                flash_guard_pkg::WRITE_UNLOCK_OFS: begin
                    next_write_unlock =
                        (reg_in.wdata == flash_guard_pkg::WRITE_UNLOCK_KEY);
                end
                flash_guard_pkg::CONFIG_LOW_OFS: begin
                    next_cfg_low = reg_in.wdata;
                end
                flash_guard_pkg::BANDGAP_TRIM_OFS: begin
                    next_trim = reg_in.wdata;
                end
                default: begin
                end
            endcase
        end
        if (reg_in.rd) begin
            case (reg_in.addr)
                flash_guard_pkg::SOFTWARE_COMMAND_OFS:
                    next_rreg = {7'h00, wide_unlock};
                flash_guard_pkg::WRITE_UNLOCK_OFS:
                    next_rreg = {write_unlock, 7'h00};
                flash_guard_pkg::CONFIG_LOW_OFS:   next_rreg = cfg_low;
                flash_guard_pkg::BANDGAP_TRIM_OFS: next_rreg = trim;
                default:                           next_rreg = 8'h00;
            endcase
        end

        case (state)
            // Configuration bytes load after power-on only; a plain reset
            // keeps software's shadow values and the lock bit.
            ST_LOAD_HI: begin
                next_lock_cfg = mem[hi_addr][flash_guard_pkg::LOCK_BIT];
                next_state    = ST_LOAD_LO;
            end
            ST_LOAD_LO: begin
                next_cfg_low = mem[lo_addr];
                next_state   = ST_LOAD_BG;
            end
            ST_LOAD_BG: begin
                next_trim  = mem[bg_addr];
                next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (acc_in.valid && !ready) begin
                    next_ready = 1'b1;
                    if (!allow) begin
                        next_blocked = 1'b1;
                        next_rvalid  = !acc_in.is_write;
                        next_rdata   = 8'h00;
                    end else if (acc_in.is_write && acc_in.is_data) begin
                        if (write_unlock) begin
                            // One byte goes straight in; no erase phase.
                            next_waddr = addr_f;
                            next_wbyte = acc_in.wdata;
                            next_cnt   = '0;
                            next_ready = 1'b0;
                            next_state = ST_WRITE;
                        end else begin
                            next_blocked = 1'b1;
                        end
                    end else if (!acc_in.is_write) begin
                        next_rvalid = 1'b1;
                        next_rdata  = mem[addr_f];
                    end
                end
            end
            ST_WRITE: begin
                // Only the CPU waits; nothing here halts peripheral clocks.
                if (cnt == WRITE_LAST) begin
                    commit     = 1'b1;
                    next_ready = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt + 18'h0_0001;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_stall = (next_state == ST_WRITE);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state        <= ST_IDLE;
            cnt          <= '0;
            wide_unlock  <= 1'b0;
            write_unlock <= 1'b0;
            ready        <= 1'b0;
            rvalid       <= 1'b0;
            rdata        <= flash_guard_pkg::BYTE_RESET;
            blocked      <= 1'b0;
            rreg         <= flash_guard_pkg::BYTE_RESET;
            waddr        <= '0;
            wbyte        <= flash_guard_pkg::BYTE_RESET;
            stall        <= 1'b0;
        end else begin
            state        <= por_in ? ST_LOAD_HI : next_state;
            cnt          <= next_cnt;
            wide_unlock  <= next_wide_unlock;
            write_unlock <= next_write_unlock;
            ready        <= next_ready;
            rvalid       <= next_rvalid;
            rdata        <= next_rdata;
            blocked      <= next_blocked;
            rreg         <= next_rreg;
            waddr        <= next_waddr;
            wbyte        <= next_wbyte;
            stall        <= !por_in && next_stall;
        end
    end

    // Shadows and lock survive a warm reset by design; only power-on reloads.
    always_ff @(posedge sys_clk_in) begin
        lock_cfg <= next_lock_cfg;
        cfg_low  <= next_cfg_low;
        trim     <= next_trim;
    end

    // A warm reset during the stall abandons the write; the cell is kept.
    always_ff @(posedge sys_clk_in) begin
        if (commit) begin
            mem[waddr] <= wbyte;
        end
    end

    assign acc_ready_out      = ready;
    assign acc_rvalid_out     = rvalid;
    assign acc_rdata_out      = rdata;
    assign acc_blocked_out    = blocked;
    assign cpu_stall_out      = stall;
    assign reg_rdata_out      = rreg;
    assign config_low_out     = cfg_low;
    assign bandgap_trim_out   = trim;
    assign fetch_lock_cfg_out = lock_cfg;

    logic unused_in_data;
    assign unused_in_data = in_data;

endmodule : flash_iap_region_guard

/* File: sim/flash_guard_properties.sv */
// Purpose: Concurrent checks on the flash guard ports.
// Assumes: Unlock flags follow register-port writes.
// Notes:   Shadow loads from flash are judged by the bench.
`timescale 1ns/10ps
module flash_guard_properties #(
    parameter int WRITE_CYCLES = 8
) (
    // Clock and reset
    input wire logic                      sys_clk_in,
    input wire logic                      rst_b_in,
    input wire logic                      por_in,
    // Flash access port
    input wire flash_guard_pkg::access_s  acc_in,
    input wire logic                      acc_ready_out,
    input wire logic                      acc_rvalid_out,
    input wire logic                      acc_blocked_out,
    input wire logic                      cpu_stall_out,
    // Register port
    input wire flash_guard_pkg::reg_req_s reg_in,
    input wire logic [7:0]                reg_rdata_out,
    input wire logic [7:0]                config_low_out
);
    logic        wide;
    logic        wen;
    logic [17:0] cnt;
    logic [13:0] a;
    wire logic   cmd_wr = reg_in.wr && reg_in.addr == 8'h97;
    wire logic   key_wr = reg_in.wr && reg_in.addr == 8'hC9;
    assign a = acc_in.addr;

    // Mirrors of both flags; any other key value clears them again.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wide <= 1'b0;
            wen  <= 1'b0;
            cnt  <= '0;
        end else begin
            if (cmd_wr) wide <= reg_in.wdata == 8'h65;
            if (key_wr) wen <= reg_in.wdata == 8'h47;
            cnt <= cpu_stall_out ? cnt + 18'h1 : '0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence take_data;
        $rose(acc_in.valid) && acc_in.is_data;
    endsequence
    sequence take_fetch;
        $rose(acc_in.valid) && !acc_in.is_data && !acc_in.is_write;
    endsequence
    sequence refused;
        acc_ready_out && acc_blocked_out;
    endsequence

    cfg_high_reject_a: assert property (
        take_data ##0 a == 14'h3FFF |=> refused)
        else $error("Top config byte data access allowed.");
    free_area_open_a: assert property (
        take_data ##0 (a >= 14'h3F00 && a <= 14'h3FEF &&
        (wen || !acc_in.is_write)) |=> !acc_blocked_out)
        else $error("Free area access refused.");
    wide_area_guard_a: assert property (
        take_data ##0 (a >= 14'h0200 && a <= 14'h3EFF && !wide) |=> refused)
        else $error("Wide area data access without unlock.");
    cfg_trim_guard_a: assert property (
        take_data ##0 (a >= 14'h3FF8 && a <= 14'h3FFE && !wide) |=> refused)
        else $error("Config byte data access without unlock.");
    fetch_open_a: assert property (
        take_fetch ##0 a > 14'h01FF |=> acc_ready_out && acc_rvalid_out &&
        !acc_blocked_out)
        else $error("Code fetch refused above lock area.");
    write_key_a: assert property (
        take_data ##0 (acc_in.is_write && !wen) |=> refused and !cpu_stall_out)
        else $error("Write accepted without write unlock.");
    stall_length_a: assert property (
        $fell(cpu_stall_out) |-> cnt == WRITE_CYCLES && acc_ready_out)
        else $error("Write stall of wrong length.");
    stall_cause_a: assert property (
        $rose(cpu_stall_out) |-> $past(acc_in.is_write) &&
        $past(acc_in.is_data) && $past(wen))
        else $error("Stall without an accepted data write.");
    cmd_flag_read_a: assert property (
        reg_in.rd && reg_in.addr == 8'h97 |=> reg_rdata_out[0] == wide)
        else $error("Command register read shows wrong flag.");
    shadow_write_a: assert property (
        reg_in.wr && reg_in.addr == 8'hF6 && !por_in |=>
        config_low_out == $past(reg_in.wdata))
        else $error("Low config shadow not overwritten.");
endmodule : flash_guard_properties

bind flash_iap_region_guard flash_guard_properties #(
    .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .por_in(por_in),
    .acc_in(acc_in), .acc_ready_out(acc_ready_out),
    .acc_rvalid_out(acc_rvalid_out), .acc_blocked_out(acc_blocked_out),
    .cpu_stall_out(cpu_stall_out), .reg_in(reg_in),
    .reg_rdata_out(reg_rdata_out), .config_low_out(config_low_out)
);

/* File: sim/cpu_access_model.sv */
// Purpose: CPU side issuing flash accesses and register cycles.
// Assumes: One request at a time, held until the guard answers.
// Notes:   Released fields are inverted so stale values never match.
`timescale 1ns/10ps
module cpu_access_model (
    // Clock
    input  wire logic                 sys_clk_in,
    // Requests
    output flash_guard_pkg::access_s  acc_out,
    output flash_guard_pkg::reg_req_s reg_out,
    // Answers
    input  wire logic                 ready_in,
    input  wire logic                 blocked_in,
    input  wire logic [7:0]           rdata_in,
    input  wire logic [7:0]           reg_rdata_in,
    // Raised when the guard never answers
    output logic                      hung_out
);
    initial begin
        acc_out  = '0;
        reg_out  = '0;
        hung_out = 1'b0;
    end

    task automatic access(input logic d, w, input logic [13:0] a,
                          input logic [7:0] wd, output logic [7:0] rd,
                          output logic b, output int n);
        n = 0;
        @(posedge sys_clk_in);
        acc_out <= '{1'b1, d, w, a, wd};
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (ready_in !== 1'b1 && n < 1000);
        if (ready_in !== 1'b1) hung_out <= 1'b1;
        rd = rdata_in;
        b = blocked_in;
        acc_out <= '{1'b0, ~d, ~w, ~a, ~wd};
    endtask : access

    task automatic reg_write(input logic [7:0] a, d);
        @(posedge sys_clk_in);
        reg_out <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk_in);
        reg_out <= '{1'b0, 1'b0, ~a, ~d};
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_out <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk_in);
        reg_out <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(posedge sys_clk_in);
        d = reg_rdata_in;
    endtask : reg_read
endmodule : cpu_access_model

/* File: sim/test_flash_iap_region_guard.sv */
// Purpose: Directed tests of the flash region guard.
// Assumes: Flash cells start erased to all ones; bytes are written first.
// Notes:   Software cannot set the lock bit, so its cases follow its value.
`timescale 1ns/10ps
module test_flash_iap_region_guard;
    localparam int   WC = 8;
    localparam logic D  = 1'b1;
    localparam logic F  = 1'b0;

    logic                      sys_clk_in;
    logic                      rst_b_in;
    logic                      por_in;
    logic                      ready;
    logic                      blocked;
    logic                      lock;
    logic                      lk;
    logic                      hung;
    logic [7:0]                rdata;
    logic [7:0]                reg_rdata;
    logic [7:0]                cfg_low;
    logic [7:0]                cfg_trim;
    flash_guard_pkg::access_s  acc;
    flash_guard_pkg::reg_req_s rq;
    int                        miscompares;
    int                        comparisons;

    flash_iap_region_guard #(.LARGE(1'b1), .WRITE_CYCLES(WC)) u_dut (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .por_in(por_in),
        .acc_in(acc), .acc_ready_out(ready), .acc_rvalid_out(),
        .acc_rdata_out(rdata), .acc_blocked_out(blocked),
        .cpu_stall_out(), .reg_in(rq), .reg_rdata_out(reg_rdata),
        .config_low_out(cfg_low), .bandgap_trim_out(cfg_trim),
        .fetch_lock_cfg_out(lock)
    );
    cpu_access_model u_cpu (
        .sys_clk_in(sys_clk_in), .acc_out(acc), .reg_out(rq),
        .ready_in(ready), .blocked_in(blocked), .rdata_in(rdata),
        .reg_rdata_in(reg_rdata), .hung_out(hung)
    );

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h, expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    // An unknown expected byte means the cell content is not predictable.
    task automatic probe(input logic d, w, input logic [13:0] a,
                         input logic [7:0] wd, input logic eb,
                         input logic [7:0] er, input int en);
        logic [7:0] rd;
        logic       b;
        int         n;
        u_cpu.access(d, w, a, wd, rd, b, n);
        chk(8'(b), 8'(eb));
        chk(8'(n), 8'(en));
        if (!w && !$isunknown(er)) chk(rd, er);
    endtask : probe

    task automatic rreg(input logic [7:0] a, m, e);
        logic [7:0] d;
        u_cpu.reg_read(a, d);
        chk(d & m, e);
    endtask : rreg

    task automatic power_on;
        @(posedge sys_clk_in) por_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        por_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
    endtask : power_on

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge hung) begin
        miscompares++;
        give_verdict();
    end

    initial begin
        rst_b_in = 1'b0;
        por_in = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        power_on();
        rreg(8'h97, 8'h01, 8'h00);
        rreg(8'hC9, 8'h80, 8'h00);
        probe(D, 1, 14'h3F00, 8'h5A, 1, 0, 2);
        $display("Test reset_state finished");
        u_cpu.reg_write(8'hC9, 8'h47);
        rreg(8'hC9, 8'h80, 8'h80);
        probe(D, 1, 14'h3F00, 8'h5A, 0, 0, WC + 2);
        probe(D, 1, 14'h3F00, 8'hA5, 0, 0, WC + 2);
        probe(D, 0, 14'h3F00, 0, 0, 8'hA5, 2);
        probe(F, 0, 14'h3F00, 0, 0, 8'hA5, 2);
        probe(D, 1, 14'h3FF2, 8'h22, 0, 0, WC + 2);
        probe(D, 1, 14'h2000, 8'h11, 1, 0, 2);
        probe(D, 1, 14'h3FFD, 8'h3C, 1, 0, 2);
        probe(D, 0, 14'h3FFF, 0, 1, 0, 2);
        probe(F, 0, 14'h3FFF, 0, 0, 8'hFF, 2);
        $display("Test narrow_map finished");
        lk = lock;
        u_cpu.reg_write(8'h97, 8'h65);
        rreg(8'h97, 8'h01, 8'h01);
        probe(D, 1, 14'h2000, 8'h66, 0, 0, WC + 2);
        probe(F, 0, 14'h2000, 0, 0, 8'h66, 2);
        probe(D, 1, 14'h3FFD, 8'h3C, 0, 0, WC + 2);
        probe(D, 1, 14'h3FFB, 8'hC3, 0, 0, WC + 2);
        probe(F, 0, 14'h3FFB, 0, 0, 8'hC3, 2);
        probe(D, 1, 14'h3FFF, 8'h00, 1, 0, 2);
        if (!$isunknown(lk)) begin
            probe(F, 0, 14'h0010, 0, lk, lk ? 8'h00 : 8'hxx, 2);
            probe(D, 1, 14'h0100, 8'h77, lk, 0, lk ? 2 : WC + 2);
        end
        u_cpu.reg_write(8'h97, 8'h12);
        rreg(8'h97, 8'h01, 8'h00);
        probe(D, 0, 14'h2000, 0, 1, 0, 2);
        chk(8'(lock), 8'(lk));
        $display("Test wide_unlock finished");
        power_on();
        chk(cfg_low, 8'h3C);
        chk(cfg_trim, 8'hC3);
        rreg(8'hF6, 8'hFF, 8'h3C);
        rreg(8'hF5, 8'hFF, 8'hC3);
        u_cpu.reg_write(8'hF6, 8'h77);
        u_cpu.reg_write(8'hF5, 8'h88);
        chk(cfg_low, 8'h77);
        rreg(8'hF5, 8'hFF, 8'h88);
        rreg(8'h10, 8'hFF, 8'h00);
        $display("Test shadow_load finished");
        u_cpu.reg_write(8'h97, 8'h65);
        @(posedge sys_clk_in) rst_b_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rreg(8'h97, 8'h01, 8'h00);
        rreg(8'hC9, 8'h80, 8'h00);
        probe(D, 0, 14'h2000, 0, 1, 0, 2);
        chk(cfg_low, 8'h77);
        $display("Test second_reset finished");
        give_verdict();
    end
endmodule : test_flash_iap_region_guard
